// File: flow_pulse_rate_scaler.sv
// Flow pulse rate scaler: BCD fraction, decade divider, output pulser
//
// Function
// - Four BCD switch digits scale rate .0000-.9999
// - Decade selector multiplies by 1 down to .0001
// - Fraction output alone feeds the decade divider
// - One output pulse per divided unit pulse, while fewer than 65535 are owed
// - No input pulses means no output pulses
// - No start command; runs as pulses arrive
// - Output pulse width 50 ms or 0.2 ms
`timescale 1ns/100ps
module flow_pulse_rate_scaler
  import flow_scaler_pkg::*;
#(
  parameter int LONG_PULSE_CYCLES  = LONG_CYCLES,
  parameter int SHORT_PULSE_CYCLES = SHORT_CYCLES
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // Conditioned flow pulse train
  input  wire logic             i_flow_pulse,
  // Scaling switches
  input  wire logic [ACC_W-1:0] i_factor_digits,
  input  wire logic [2:0]       i_decade_sel,
  input  wire logic             i_long_pulse,
  // Host side
  output logic                  o_unit_pulse,
  output logic                  o_busy
);

  // Timer reload values, one less than the width in cycles
  // A width of one loads zero and still gives one cycle high
  localparam logic [TIMER_W-1:0] LONG_LOAD  =
    TIMER_W'(LONG_PULSE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SHORT_LOAD =
    TIMER_W'(SHORT_PULSE_CYCLES - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 23'h000000;

  // Whole block state
  typedef struct packed {
    // Input edge detect
    logic                flow_q;
    // Fraction stage
    logic [ACC_W-1:0]    acc;
    logic                frac_pulse;
    // Decade divider
    logic [DIV_W-1:0]    div_cnt;
    logic                unit_pulse;
    // Output pulser
    logic [OWED_W-1:0]   owed;
    phase_t              phase;
    logic [TIMER_W-1:0]  timer;
    logic                long_sel;
    // Registered outputs
    logic                out_pulse;
    logic                busy;
  } state_t;

  state_t st;
  state_t next_st;

  // Adder chain results
  logic [ACC_W-1:0] acc_sum;
  logic [DIGITS:0]  carry;

  // No carry into the lowest digit
  assign carry[0] = 1'b0;

  // Accumulator plus switch setting, digit by digit
  // Top carry is the wrap past 9999, the fraction pulse
  for (genvar d = 0; d < DIGITS; d++) begin : g_digit
    bcd_digit_add u_digit (
      .i_acc_digit (st.acc[4*d +: 4]),
      .i_set_digit (i_factor_digits[4*d +: 4]),
      .i_carry     (carry[d]),
      .o_sum_digit (acc_sum[4*d +: 4]),
      .o_carry     (carry[d+1])
    );
  end

  // Decade divider terminal count for the selector
  // Pure decode of the selector switch; no state
  function automatic logic [DIV_W-1:0] div_limit(input logic [2:0] sel);
    logic [DIV_W-1:0] lim;
    case (sel)
      SEL_X1:      lim = DIV_1;
      SEL_X0P1:    lim = DIV_10;
      SEL_X0P01:   lim = DIV_100;
      SEL_X0P001:  lim = DIV_1000;
      SEL_X0P0001: lim = DIV_10000;
      default:     lim = DIV_1; // Unused codes act as times one
    endcase
    return lim;
  endfunction

  // Per-cycle helpers of the next-state process
  logic             flow_edge;
  logic [DIV_W-1:0] limit;
  logic [DIV_W-1:0] div_inc;
  logic             owe_add;
  logic             owe_take;

  // Next state
  always_comb begin
    // Hold everything unless a stage moves it
    next_st   = st;
    flow_edge = i_flow_pulse & ~st.flow_q;
    limit     = div_limit(i_decade_sel);
    div_inc   = st.div_cnt + 14'h0001;
    owe_add   = 1'b0;
    owe_take  = 1'b0;

    // Previous input level for the edge detect
    next_st.flow_q = i_flow_pulse;

    // Fraction stage steps only on an input edge; idle input stays idle
    // Remainder stays in the accumulator, so no flow is lost
    next_st.frac_pulse = 1'b0;
    if (flow_edge) begin
      next_st.acc        = acc_sum;
      next_st.frac_pulse = carry[DIGITS];
    end

    // Decade divider sees fraction pulses and nothing else
    // Count survives selector changes; a lower limit fires next
    next_st.unit_pulse = 1'b0;
    if (st.frac_pulse) begin
      if (div_inc >= limit) begin
        next_st.div_cnt    = DIV_RESET;
        next_st.unit_pulse = 1'b1;
      end else begin
        next_st.div_cnt = div_inc;
      end
    end

    // Output pulser; owed count keeps up to 65535 units during a long pulse
    owe_add = st.unit_pulse;

    // Idle, high for the width, low for the width, then idle
    case (st.phase)
      PH_IDLE: begin
        // No enable needed: any owed unit starts a pulse
        if (st.owed != OWED_RESET || st.unit_pulse) begin
          owe_take         = 1'b1;
          next_st.phase    = PH_HIGH;
          next_st.long_sel = i_long_pulse;
          next_st.timer    = i_long_pulse ? LONG_LOAD : SHORT_LOAD;
        end
      end

      PH_HIGH: begin
        // Counts the high time down to zero
        if (st.timer == TIMER_ZERO) begin
          // Low gap as long as the pulse, so counters see each one
          next_st.phase = PH_GAP;
          next_st.timer = st.long_sel ? LONG_LOAD : SHORT_LOAD;
        end else begin
          next_st.timer = st.timer - 23'h000001;
        end
      end

      PH_GAP: begin
        // Low gap ends in idle; owed units restart there
        if (st.timer == TIMER_ZERO) begin
          next_st.phase = PH_IDLE;
        end else begin
          next_st.timer = st.timer - 23'h000001;
        end
      end

      default: begin
        // Unknown phase code recovers to idle
        next_st.phase = PH_IDLE;
        next_st.timer = TIMER_ZERO;
      end
    endcase

    // Owed count: add and take may coincide and cancel
    // Saturates at the top; units beyond it are lost
    if (owe_add && !owe_take) begin
      if (st.owed != OWED_MAX) begin
        next_st.owed = st.owed + 16'h0001;
      end
    end else if (owe_take && !owe_add) begin
      next_st.owed = st.owed - 16'h0001;
    end

    // Taken from the next state so each output is a flip-flop
    next_st.out_pulse = (next_st.phase == PH_HIGH);
    next_st.busy      = (next_st.phase != PH_IDLE)
                        || (next_st.owed != OWED_RESET);
  end

  // State register
  // Synchronous reset clears every field together
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      // Empty pipeline, idle pulser, outputs low
      st.flow_q     <= 1'b0;
      st.acc        <= ACC_RESET;
      st.frac_pulse <= 1'b0;
      st.div_cnt    <= DIV_RESET;
      st.unit_pulse <= 1'b0;
      st.owed       <= OWED_RESET;
      st.phase      <= PH_IDLE;
      st.timer      <= TIMER_ZERO;
      st.long_sel   <= 1'b0;
      st.out_pulse  <= 1'b0;
      st.busy       <= 1'b0;
    end else begin
      // Every register moves on every edge
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign o_unit_pulse = st.out_pulse;
  assign o_busy       = st.busy;

endmodule // flow_pulse_rate_scaler

// File: flow_scaler_pkg.sv
// Shared constants and types for the flow pulse rate scaler
package flow_scaler_pkg;

  // Logic clock
  localparam int CLK_FREQ_HZ    = 100_000_000;

  // Output pulse durations as printed
  localparam int PULSE_LONG_MS  = 50;   // Totalizer variant
  localparam int PULSE_SHORT_US = 200;  // Digital electronics variant

  // Durations in clock cycles (exact multiples at this rate)
  localparam int LONG_CYCLES    = PULSE_LONG_MS * (CLK_FREQ_HZ / 1000);
  localparam int SHORT_CYCLES   = PULSE_SHORT_US * (CLK_FREQ_HZ / 1000000);

  // Pulse timer width, wide enough for LONG_CYCLES
  localparam int TIMER_W        = 23;

  // Fraction stage: four BCD digits
  localparam int DIGITS         = 4;
  localparam int ACC_W          = 4 * DIGITS;
  localparam logic [ACC_W-1:0] ACC_RESET = 16'h0000;
  localparam logic [3:0] BCD_MAX = 4'h9;

  // Decade selector codes
  localparam logic [2:0] SEL_X1     = 3'h0;
  localparam logic [2:0] SEL_X0P1   = 3'h1;
  localparam logic [2:0] SEL_X0P01  = 3'h2;
  localparam logic [2:0] SEL_X0P001 = 3'h3;
  localparam logic [2:0] SEL_X0P0001 = 3'h4;

  // Decade divider terminal counts
  localparam int DIV_W = 14;
  localparam logic [DIV_W-1:0] DIV_1     = 14'h0001;
  localparam logic [DIV_W-1:0] DIV_10    = 14'h000a;
  localparam logic [DIV_W-1:0] DIV_100   = 14'h0064;
  localparam logic [DIV_W-1:0] DIV_1000  = 14'h03e8;
  localparam logic [DIV_W-1:0] DIV_10000 = 14'h2710;
  localparam logic [DIV_W-1:0] DIV_RESET = 14'h0000;

  // Owed output pulses
  localparam int OWED_W = 16;
  localparam logic [OWED_W-1:0] OWED_RESET = 16'h0000;
  localparam logic [OWED_W-1:0] OWED_MAX   = 16'hffff;

  // Output stage phases
  typedef enum logic [2:0] {
    PH_IDLE = 3'b001,
    PH_HIGH = 3'b010,
    PH_GAP  = 3'b100
  } phase_t;

endpackage

// File: bcd_digit_add.sv
// One BCD digit adder with carry, used for the fraction accumulator
`timescale 1ns/100ps
module bcd_digit_add
  import flow_scaler_pkg::*;
(
  // Operands
  input  wire logic [3:0] i_acc_digit,
  input  wire logic [3:0] i_set_digit,
  input  wire logic       i_carry,
  // Result
  output logic      [3:0] o_sum_digit,
  output logic            o_carry
);

  logic [3:0] set_clamped;
  logic [4:0] raw;

  // Non-decimal switch codes are taken as nine
  always_comb begin
    set_clamped = (i_set_digit > BCD_MAX) ? BCD_MAX : i_set_digit;
    raw         = {1'b0, i_acc_digit} + {1'b0, set_clamped}
                  + {4'h0, i_carry};
    if (raw > {1'b0, BCD_MAX}) begin
      o_sum_digit = 4'(raw - 5'h0a);
      o_carry     = 1'b1;
    end else begin
      o_sum_digit = raw[3:0];
      o_carry     = 1'b0;
    end
  end

endmodule // bcd_digit_add

// File: flow_scaler_properties.sv
// Port assertions for the flow pulse rate scaler
`timescale 1ns/100ps
module flow_scaler_properties
  import flow_scaler_pkg::*;
#(
  parameter int LONG_PULSE_CYCLES  = 8,
  parameter int SHORT_PULSE_CYCLES = 3
) (
  // Clock, reset, pulse train and switches
  input wire logic             i_ref_clk,
  input wire logic             i_rst,
  input wire logic             i_flow_pulse,
  input wire logic [ACC_W-1:0] i_factor_digits,
  input wire logic [2:0]       i_decade_sel,
  input wire logic             i_long_pulse,
  // Host side
  input wire logic             o_unit_pulse,
  input wire logic             o_busy
);
  int         w;
  logic [7:0] run;
  logic [7:0] gap;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  assign w = i_long_pulse ? LONG_PULSE_CYCLES : SHORT_PULSE_CYCLES;
  // High and low run lengths; gap saturates so reset reads as long idle
  always_ff @(posedge i_ref_clk) begin
    run <= o_unit_pulse ? run + 8'h01 : 8'h00;
    gap <= o_unit_pulse ? 8'h00 : (i_rst || &gap) ? 8'hff : gap + 8'h01;
  end
  AST_WIDTH: assert property ($fell(o_unit_pulse) |-> run == w)
    else $error("unit pulse width off");
  AST_GAP: assert property ($rose(o_unit_pulse) |-> gap >= w)
    else $error("unit pulses too close");
  AST_BUSY: assert property (o_unit_pulse |-> o_busy)
    else $error("pulse without busy");
  AST_DRAIN: assert property (
    $fell(o_busy) |-> !o_unit_pulse && gap >= w)
    else $error("busy dropped early");
  AST_QUIET: assert property (
    (!o_busy && !i_flow_pulse) [*5] |=> !o_unit_pulse)
    else $error("spontaneous pulse");
  // Input edge sampled three edges before the pulse is first seen high
  AST_START: assert property (
    $rose(o_unit_pulse) && !$past(o_busy) |->
    $past(i_flow_pulse, 3) && !$past(i_flow_pulse, 4))
    else $error("pulse not from input edge");
  AST_ZERO: assert property (
    (i_factor_digits == 16'h0000 && !o_busy) [*5] |=> !o_busy)
    else $error("zero factor gave output");
  AST_RESET: assert property (
    $fell(i_rst) |-> !o_unit_pulse && !o_busy)
    else $error("outputs not idle after reset");
endmodule // flow_scaler_properties

bind flow_pulse_rate_scaler flow_scaler_properties #(
  .LONG_PULSE_CYCLES (LONG_PULSE_CYCLES),
  .SHORT_PULSE_CYCLES(SHORT_PULSE_CYCLES)
) u_props (
  .i_ref_clk      (i_ref_clk),
  .i_rst          (i_rst),
  .i_flow_pulse   (i_flow_pulse),
  .i_factor_digits(i_factor_digits),
  .i_decade_sel   (i_decade_sel),
  .i_long_pulse   (i_long_pulse),
  .o_unit_pulse   (o_unit_pulse),
  .o_busy         (o_busy)
);

// File: unit_pulse_counter.sv
// Host totalizer model: counts scaled unit pulses
`timescale 1ns/100ps
module unit_pulse_counter (
  // Clock and reset
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // Scaled output of the device
  input  wire logic        i_unit_pulse,
  // Units totalled since reset; four-state so an unknown shows
  output logic      [31:0] o_total
);
  logic prev;
  // Counts rising edges only; width is left to the checker
  always_ff @(posedge i_ref_clk) begin
    prev    <= i_rst ? 1'b0 : i_unit_pulse;
    o_total <= i_rst ? 32'h0 : o_total + 32'(i_unit_pulse && !prev);
  end
endmodule // unit_pulse_counter

// File: tb.sv
// Self-checking bench for the flow pulse rate scaler
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin \
  err_total++; \
  $display("wrong value %s exp %0d got %0d", nm, ex, got); end end
module tb;
  import flow_scaler_pkg::*;
  logic             clk;
  logic             rst;
  logic             pulse;
  logic [ACC_W-1:0] digits;
  logic [2:0]       sel;
  logic             long_p;
  logic             unit;
  logic             busy;
  logic [31:0]      total;
  int               err_total;
  int               compares;
  int               seed = 32'hc532b3fd;
  // Small widths keep the run short: 8 and 3 cycles
  flow_pulse_rate_scaler #(.LONG_PULSE_CYCLES(8), .SHORT_PULSE_CYCLES(3))
    u_flow_pulse_rate_scaler (.i_ref_clk(clk), .i_rst(rst),
    .i_flow_pulse(pulse), .i_factor_digits(digits), .i_decade_sel(sel),
    .i_long_pulse(long_p), .o_unit_pulse(unit), .o_busy(busy));
  unit_pulse_counter u_unit_pulse_counter (.i_ref_clk(clk), .i_rst(rst),
    .i_unit_pulse(unit), .o_total(total));
  // Expected units from reset: carries of the decimal sum, then decade
  function automatic int expect_units(logic [15:0] d, logic [2:0] s, int k);
    int f;
    f = 0;
    for (int i = 3; i >= 0; i--)
      f = f * 10 + ((d[i*4+:4] > 4'h9) ? 9 : int'(d[i*4+:4]));
    return (k * f / 10000) / ((s > 3'h4) ? 1 : 10 ** int'(s));
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Reset, send k input edges with random spacing, drain and compare
  task automatic run(logic [15:0] d, logic [2:0] s, logic lp, int k);
    int n;
    rst = 1'b1;
    digits = d;
    sel = s;
    long_p = lp;
    tick(2);
    rst = 1'b0;
    tick(1);
    for (int i = 0; i < k; i++) begin
      pulse = 1'b1;
      tick(1);
      pulse = 1'b0;
      tick(1 + ($unsigned($random(seed)) % 3));
    end
    tick(6);
    n = 0;
    while (busy !== 1'b0 && n < 40000) begin
      tick(1);
      n++;
    end
    tick(4);
    `CHK("unit count", expect_units(d, s, k), total)
    `CHK("busy drained", 1'b0, busy)
    $display("test done sel %0d factor %h edges %0d", s, d, k);
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog, under twice the expected run length
  initial begin
    #800us;
    err_total++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    pulse = 1'b0;
    digits = 16'h0000;
    sel = 3'h0;
    long_p = 1'b0;
    err_total = 0;
    compares = 0;
    tick(2);
    // Corners: silence, zero factor, clamped digits, long pulse, top decade
    run(16'h0000, 3'h0, 1'b0, 0);
    run(16'h0000, 3'h0, 1'b0, 50);
    run(16'hffff, 3'h0, 1'b1, 60);
    run(16'h9999, 3'h4, 1'b0, 10002);
    run(16'h5000, 3'h1, 1'b0, 41);
    // Random factors over every selector code, clamped ones included
    for (int s = 0; s < 8; s++)
      run(16'($random(seed)), 3'(s), 1'b0, 300);
    wrap_up();
  end
endmodule // tb
